//--- lcgis_pkg.sv
// Package holding the register map, field layout and decode helpers of the gate select stage.
// Contract
// - gate one true-enables at low bits 7,5,3,1
// - gate one negated-enables at low bits 6,4,2,0
// - gate two source one negated at bit 8
// - gate four selects in high bits 15..8
// - gate three selects in high bits 7..0
// - true-enable set passes source uninverted
// - negated-enable set passes inverted source
// - cleared enable excludes that source form
// - gate two sources four..two in bits 15..10
// - polarity bit set inverts the gate output
// - four 3-bit muxes pick each data source
package lcgis_pkg;

  // ==========================================================================
  // Bus and register map
  localparam int LCGIS_ADDR_LSB = 2;
  localparam int LCGIS_IDX_W = 3;
  localparam int LCGIS_MAP_TOP = 5;
  localparam logic [2:0] LCGIS_IDX_GLSL = 3'h0;
  localparam logic [2:0] LCGIS_IDX_GLSH = 3'h1;
  localparam logic [2:0] LCGIS_IDX_POL = 3'h2;
  localparam logic [2:0] LCGIS_IDX_DSEL = 3'h3;
  localparam logic [2:0] LCGIS_IDX_STAT = 3'h4;
  localparam logic [1:0] LCGIS_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] LCGIS_HTRANS_SEQ = 2'h3;
  localparam logic LCGIS_HRESP_OKAY = 1'b0;

  // ==========================================================================
  // Field layout and reset values
  localparam int LCGIS_GATES = 4;
  localparam int LCGIS_SRCS = 4;
  localparam int LCGIS_MUX_IN = 8;
  localparam int LCGIS_GSEL_W = 8;
  localparam int LCGIS_DSEL_W = 3;
  localparam int LCGIS_DSEL_STRIDE = 4;
  localparam int LCGIS_STAT_SRC_LSB = 4;
  localparam logic [15:0] LCGIS_GLSL_RST = 16'h0000;
  localparam logic [15:0] LCGIS_GLSH_RST = 16'h0000;
  localparam logic [3:0] LCGIS_POL_RST = 4'h0;
  localparam logic [15:0] LCGIS_DSEL_RST = 16'h0000;
  localparam logic [15:0] LCGIS_DSEL_MASK = 16'h7777;

  // ==========================================================================
  // Decode helpers
  function automatic logic lcgis_pick(input logic [7:0] cand, input logic [2:0] sel);
    lcgis_pick = cand[sel];
  endfunction

  function automatic logic [2:0] lcgis_dsel_field(input logic [15:0] dsel, input int k);
    lcgis_dsel_field = dsel[k * LCGIS_DSEL_STRIDE +: LCGIS_DSEL_W];
  endfunction

endpackage

//--- lcgis_gate.sv
// One gate channel: OR of enabled true and negated source forms, then polarity.
`timescale 1ns/1ps
module lcgis_gate
  import lcgis_pkg::*;
(
  input wire logic [7:0] sel_i,
  input wire logic [3:0] src_i,
  input wire logic invert_i,
  output logic gate_o
);

  logic acc;

  always_comb begin
    acc = 1'b0;
    for (int k = 0; k < LCGIS_SRCS; k++) begin
      // Odd bit passes the source, even bit its inverse; a clear bit adds nothing.
      acc = acc | (sel_i[2 * k + 1] & src_i[k]);
      acc = acc | (sel_i[2 * k] & ~src_i[k]);
    end
    // With no enable set the OR stays 0 before the polarity stage.
    gate_o = acc ^ invert_i;
  end

endmodule

//--- lcgis_top.sv
// Gate input select stage with its AHB-Lite register slave.
`timescale 1ns/1ps
module lcgis_top
  import lcgis_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [7:0] src_one_cand_i,
  input wire logic [7:0] src_two_cand_i,
  input wire logic [7:0] src_three_cand_i,
  input wire logic [7:0] src_four_cand_i,
  output logic [3:0] gate_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [15:0] glsl;
    logic [15:0] glsh;
    logic [3:0] pol;
    logic [15:0] dsel;
    logic wr_pend;
    logic [2:0] wr_idx;
    logic [31:0] rdata;
    logic hready;
    logic [3:0] gate;
  } lcgis_state_type;

  lcgis_state_type r_q;
  lcgis_state_type r_d;

  logic [3:0] src;
  logic [3:0] gate_raw;
  logic [31:0] gsel;
  logic addr_take;
  logic addr_ok;
  logic [2:0] addr_idx;
  logic [31:0] status;

  // ==========================================================================
  // Data source multiplexers
  // Pins reach the muxes only through the second synchroniser stage.
  genvar gs;
  generate
    for (gs = 0; gs < LCGIS_SRCS; gs++) begin : g_src
      assign src[gs] = lcgis_pick(r_q.sync2[gs * LCGIS_MUX_IN +: LCGIS_MUX_IN],
                                  lcgis_dsel_field(r_q.dsel, gs));
    end
  endgenerate

  // ==========================================================================
  // Gate channels
  // Low register: gate one in bits 7..0, gate two in 15..8; high: three, four.
  assign gsel = {r_q.glsh, r_q.glsl};

  genvar gg;
  generate
    for (gg = 0; gg < LCGIS_GATES; gg++) begin : g_gate
      lcgis_gate u_gate (
        .sel_i(gsel[gg * LCGIS_GSEL_W +: LCGIS_GSEL_W]),
        .src_i(src),
        .invert_i(r_q.pol[gg]),
        .gate_o(gate_raw[gg])
      );
    end
  endgenerate

  // ==========================================================================
  // Bus decode
  assign addr_take = hsel_i & hready_i & htrans_i[1];
  assign addr_idx = haddr_i[LCGIS_ADDR_LSB +: LCGIS_IDX_W];
  assign addr_ok = (haddr_i[31:LCGIS_ADDR_LSB + LCGIS_IDX_W] == '0) &&
                   (32'(addr_idx) < 32'(LCGIS_MAP_TOP));
  assign status = {24'h000000, src, r_q.gate};

  // ==========================================================================
  // Next state
  always_comb begin
    r_d = r_q;
    r_d.sync1 = {src_four_cand_i, src_three_cand_i, src_two_cand_i, src_one_cand_i};
    r_d.sync2 = r_q.sync1;
    r_d.gate = gate_raw;
    r_d.hready = 1'b1;
    // Write data phase: hwdata belongs to the address taken one cycle earlier.
    if (r_q.wr_pend) begin
      case (r_q.wr_idx)
        LCGIS_IDX_GLSL: begin
          r_d.glsl = hwdata_i[15:0];
        end
        LCGIS_IDX_GLSH: begin
          r_d.glsh = hwdata_i[15:0];
        end
        LCGIS_IDX_POL: begin
          r_d.pol = hwdata_i[3:0];
        end
        LCGIS_IDX_DSEL: begin
          r_d.dsel = hwdata_i[15:0] & LCGIS_DSEL_MASK;
        end
        default: begin
          r_d.pol = r_q.pol;
        end
      endcase
    end
    // Reads sample the post-write copy so a read right after a write sees it.
    r_d.wr_pend = 1'b0;
    r_d.wr_idx = r_q.wr_idx;
    if (addr_take) begin
      r_d.wr_pend = hwrite_i & addr_ok & (addr_idx != LCGIS_IDX_STAT);
      r_d.wr_idx = addr_idx;
    end
    r_d.rdata = '0;
    if (addr_take && !hwrite_i && addr_ok) begin
      case (addr_idx)
        LCGIS_IDX_GLSL: begin
          r_d.rdata = {16'h0000, r_d.glsl};
        end
        LCGIS_IDX_GLSH: begin
          r_d.rdata = {16'h0000, r_d.glsh};
        end
        LCGIS_IDX_POL: begin
          r_d.rdata = {28'h0000000, r_d.pol};
        end
        LCGIS_IDX_DSEL: begin
          r_d.rdata = {16'h0000, r_d.dsel};
        end
        LCGIS_IDX_STAT: begin
          r_d.rdata = status;
        end
        default: begin
          r_d.rdata = '0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      r_q.sync1 <= '0;
      r_q.sync2 <= '0;
      r_q.glsl <= LCGIS_GLSL_RST;
      r_q.glsh <= LCGIS_GLSH_RST;
      r_q.pol <= LCGIS_POL_RST;
      r_q.dsel <= LCGIS_DSEL_RST;
      r_q.wr_pend <= 1'b0;
      r_q.wr_idx <= LCGIS_IDX_GLSL;
      r_q.rdata <= '0;
      r_q.hready <= 1'b1;
      r_q.gate <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign hrdata_o = r_q.rdata;
  assign hreadyout_o = r_q.hready;
  assign hresp_o = LCGIS_HRESP_OKAY;
  assign gate_o = r_q.gate;

  // ==========================================================================
  // Checks
  logic pick_one;
  assign pick_one = src_one_cand_i[r_q.dsel[2:0]];

  gate_one_true_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (r_q.glsl[7:0] == 8'h02 && !r_q.pol[0]) |=> gate_o[0] == $past(src[0]))
    else $error("gate one true select of source one wrong");

  gate_one_neg_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (r_q.glsl[7:0] == 8'h40 && !r_q.pol[0]) |=> gate_o[0] == !$past(src[3]))
    else $error("gate one negated select of source four wrong");

  gate_two_bit8_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (r_q.glsl[15:8] == 8'h01 && !r_q.pol[1]) |=> gate_o[1] == !$past(src[0]))
    else $error("gate two negated source one wrong");

  gate_two_high_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (r_q.glsl[15:8] == 8'h20 && !r_q.pol[1]) |=> gate_o[1] == $past(src[2]))
    else $error("gate two true source three wrong");

  gate_four_sel_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (r_q.glsh[15:8] == 8'h80 && !r_q.pol[3]) |=> gate_o[3] == $past(src[3]))
    else $error("gate four true source four wrong");

  gate_three_sel_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (r_q.glsh[7:0] == 8'h04 && !r_q.pol[2]) |=> gate_o[2] == !$past(src[1]))
    else $error("gate three negated source two wrong");

  gate_empty_zero_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (r_q.glsh[7:0] == 8'h00 && !r_q.pol[2]) [*2] |-> gate_o[2] == 1'b0)
    else $error("gate three not zero with no select");

  gate_polarity_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (r_q.glsh[15:8] == 8'h00 && r_q.pol[3]) [*2] |-> gate_o[3] == 1'b1)
    else $error("gate four polarity not applied");

  // Reset clears the synchroniser, so pin history from before it says nothing.
  source_mux_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    !$past(reset_i) && !$past(reset_i, 2) &&
    $stable(r_q.dsel) && $past(r_q.dsel) == $past(r_q.dsel, 2)
    |-> src[0] == $past(pick_one, 2))
    else $error("source one mux does not follow its select");

  bus_okay_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    addr_take |=> hreadyout_o && hresp_o == LCGIS_HRESP_OKAY)
    else $error("bus answer not ready or not okay");

  gate_both_forms_c: cover property (@(posedge mclk_i) disable iff (reset_i)
    r_q.glsl[1:0] == 2'h3 ##1 gate_o[0]);
  write_then_read_c: cover property (@(posedge mclk_i) disable iff (reset_i)
    (addr_take && hwrite_i) ##1 (addr_take && !hwrite_i));
  polarity_flip_c: cover property (@(posedge mclk_i) disable iff (reset_i)
    $rose(r_q.pol[0]) ##1 $changed(gate_o[0]));

endmodule

//--- test_logic_cell_gate_input_select.sv
// Self-checking bench for the gate input select stage and its register slave.
`timescale 1ns/1ps
module test_logic_cell_gate_input_select
  import lcgis_pkg::*;
;
  typedef struct {
    logic [15:0] lo;
    logic [15:0] hi;
    logic [3:0] pol;
    logic [3:0] src;
    logic [3:0] exp;
  } lcgis_row_type;
  // ==========================================================================
  // Stimulus and observed signals
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel_i = 1'b1;
  logic hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [7:0] cand [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic [3:0] gate_o;
  logic [31:0] rd;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  lcgis_row_type rows [13] = '{
    '{16'h0002, 16'h0000, 4'h0, 4'h1, 4'h1},
    '{16'h0001, 16'h0000, 4'h0, 4'h0, 4'h1},
    '{16'h0080, 16'h0000, 4'h0, 4'h7, 4'h0},
    '{16'h0100, 16'h0000, 4'h0, 4'h0, 4'h2},
    '{16'h8000, 16'h0000, 4'h0, 4'h8, 4'h2},
    '{16'h0000, 16'h0040, 4'h0, 4'h7, 4'h4},
    '{16'h0000, 16'h0200, 4'h0, 4'h1, 4'h8},
    '{16'h0000, 16'h0000, 4'hF, 4'hF, 4'hF},
    '{16'h0000, 16'h2000, 4'h1, 4'h4, 4'h9},
    '{16'h0C00, 16'h0000, 4'h0, 4'h0, 4'h2},
    '{16'h0028, 16'h0000, 4'h0, 4'h2, 4'h1},
    '{16'h2040, 16'h8004, 4'h0, 4'hC, 4'hE},
    '{16'h2040, 16'h8004, 4'h0, 4'h3, 4'h1}
  };

  lcgis_top DUT (
    .mclk_i(mclk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .src_one_cand_i(cand[0]), .src_two_cand_i(cand[1]),
    .src_three_cand_i(cand[2]), .src_four_cand_i(cand[3]), .gate_o(gate_o)
  );

  always #4 mclk_i = ~mclk_i;

  // A hung bus wait would otherwise stall the run forever.
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Bus and compare tasks, entered just after a rising edge
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    htrans_i <= LCGIS_HTRANS_NONSEQ;
    haddr_i <= addr;
    hwrite_i <= wr;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    rd = hrdata_o;
    chk("response", {31'h0, LCGIS_HRESP_OKAY}, {31'h0, hresp_o});
  endtask

  task automatic wr(input logic [2:0] idx, input logic [31:0] d);
    xfer(1'b1, {27'h0, idx, 2'h0}, d);
  endtask

  task automatic rdchk(input logic [2:0] idx, input logic [31:0] exp);
    xfer(1'b0, {27'h0, idx, 2'h0}, 32'h0);
    chk("register", exp, rd);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    rdchk(LCGIS_IDX_GLSL, 32'h0);
    rdchk(LCGIS_IDX_GLSH, 32'h0);
    foreach (rows[i]) begin
      wr(LCGIS_IDX_GLSL, {16'h0, rows[i].lo});
      wr(LCGIS_IDX_GLSH, {16'h0, rows[i].hi});
      wr(LCGIS_IDX_POL, {28'h0, rows[i].pol});
      for (int k = 0; k < 4; k++) cand[k] <= {7'h0, rows[i].src[k]};
      repeat (5) @(posedge mclk_i);
      chk("gate", {28'h0, rows[i].exp}, {28'h0, gate_o});
      rdchk(LCGIS_IDX_GLSL, {16'h0, rows[i].lo});
      rdchk(LCGIS_IDX_GLSH, {16'h0, rows[i].hi});
      $display("row %0d done", i);
    end
    // Only the low sixteen bits of each select register exist.
    wr(LCGIS_IDX_GLSL, 32'hFFFFFFFF);
    rdchk(LCGIS_IDX_GLSL, 32'h0000FFFF);
    wr(LCGIS_IDX_GLSH, 32'hFFFFFFFF);
    rdchk(LCGIS_IDX_GLSH, 32'h0000FFFF);
    wr(3'h7, 32'hFFFFFFFF);
    rdchk(3'h7, 32'h0);
    $display("width and unmapped test done");
    wr(LCGIS_IDX_GLSL, 32'h00000002);
    wr(LCGIS_IDX_GLSH, 32'h0);
    wr(LCGIS_IDX_POL, 32'h0);
    for (int s = 0; s < 8; s++) begin
      wr(LCGIS_IDX_DSEL, s);
      cand[0] <= 8'h01 << s;
      repeat (5) @(posedge mclk_i);
      chk("gate", 32'h1, {28'h0, gate_o});
      cand[0] <= ~(8'h01 << s);
      repeat (5) @(posedge mclk_i);
      chk("gate", 32'h0, {28'h0, gate_o});
    end
    $display("source select test done");
    // Source one shows pin bit 7 (low), source two the last row's 1, gates all low.
    rdchk(LCGIS_IDX_STAT, 32'h00000020);
    wr(LCGIS_IDX_STAT, 32'hFFFFFFFF);
    rdchk(LCGIS_IDX_STAT, 32'h00000020);
    wr(LCGIS_IDX_DSEL, 32'hFFFFFFFF);
    rdchk(LCGIS_IDX_DSEL, {16'h0, LCGIS_DSEL_MASK});
    $display("status and mux select test done");
    wr(LCGIS_IDX_POL, 32'hF);
    reset_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk("gate", 32'h0, {28'h0, gate_o});
    chk("ready", 32'h1, {31'h0, hreadyout_o});
    reset_i <= 1'b0;
    @(posedge mclk_i);
    rdchk(LCGIS_IDX_GLSL, 32'h0);
    rdchk(LCGIS_IDX_POL, 32'h0);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule
